// ===== verilog/ssdr_pkg.sv
package ssdr_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_DATA_BUFFER   = 8'h21;
    localparam logic [7:0] ADDR_CONTROL       = 8'h22;
    localparam logic [7:0] ADDR_CONTROL_STAT  = 8'h23;
    localparam logic [7:0] ADDR_EVT_STATUS    = 8'h24;
    localparam logic [7:0] ADDR_EVT_CLEAR     = 8'h25;
    localparam logic [7:0] ADDR_EVT_ENABLE    = 8'h26;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int CR_IRQ_ENABLE    = 7;
    localparam int CR_PORT_ENABLE   = 6;
    localparam int CR_RATE_HI       = 5;
    localparam int CR_MASTER_SELECT = 4;
    localparam int CR_CPOL          = 3;
    localparam int CR_CPHA          = 2;
    localparam int CR_RATE_MID      = 1;
    localparam int CR_RATE_LO       = 0;
    localparam logic [7:0] CR_RESET = 8'h00;

    // ------------------------------------------------------------
    // Control/status register fields
    // ------------------------------------------------------------
    localparam int CSR_TRANSFER_DONE  = 7;
    localparam int CSR_WRITE_COLL     = 6;
    localparam int CSR_OVERRUN        = 5;
    localparam int CSR_MODE_FAULT     = 4;
    localparam int CSR_OUTPUT_DISABLE = 2;
    localparam int CSR_SELECT_SOFT    = 1;
    localparam int CSR_SOFT_LEVEL     = 0;
    localparam logic [7:0] CSR_RESET  = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;

    // ------------------------------------------------------------
    // Event status bits
    // ------------------------------------------------------------
    localparam int EVT_DONE     = 0;
    localparam int EVT_OVERRUN  = 1;
    localparam int EVT_FAULT    = 2;
    localparam int EVT_W        = 3;
    localparam logic [2:0] EVT_RESET = 3'h0;

    // ------------------------------------------------------------
    // Timing: clock edges per byte, serial clock ratio
    // ------------------------------------------------------------
    localparam logic [4:0] EDGES_PER_BYTE = 5'h10;

    // Half period in cycles minus one, for divide ratios 4..128
    function automatic logic [6:0] half_count(input logic [2:0] rate);
        case (rate)
            3'h4:    half_count = 7'h01;
            3'h0:    half_count = 7'h03;
            3'h1:    half_count = 7'h07;
            3'h6:    half_count = 7'h0F;
            3'h2:    half_count = 7'h1F;
            3'h3:    half_count = 7'h3F;
            default: half_count = 7'h03;
        endcase
    endfunction : half_count

endpackage : ssdr_pkg

// ===== verilog/ssdr_sync.sv
`timescale 1ns/1ps
module ssdr_sync #(
    parameter int W = 4
) (
    input  wire logic         clk_sys,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] d_async,
    output logic      [W-1:0] d_sync
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            meta_ff <= '0;
            sync_ff <= '0;
        end
        else
        begin
            meta_ff <= d_async;
            sync_ff <= meta_ff;
        end
    end

    assign d_sync = sync_ff;
endmodule : ssdr_sync

// ===== verilog/ssdr_shift.sv
`timescale 1ns/1ps
module ssdr_shift (
    input  wire logic       clk_sys,
    input  wire logic       sys_rst,
    input  wire logic       en,
    input  wire logic       master,
    input  wire logic       cpol,
    input  wire logic       cpha,
    input  wire logic [2:0] rate,
    input  wire logic       load,
    input  wire logic [7:0] load_data,
    input  wire logic       sck_s,
    input  wire logic       din_s,
    input  wire logic       sel_active,
    output logic            busy,
    output logic            done,
    output logic [7:0]      rx_byte,
    output logic            sck_drv,
    output logic            dout
);
    import ssdr_pkg::*;

    logic [7:0] shreg_ff;
    logic       out_ff;
    logic [4:0] edges_ff;
    logic       run_ff;
    logic       sck_ff;
    logic       sck_prev_ff;
    logic [6:0] div_ff;
    logic       done_ff;

    wire  [6:0] half     = half_count(rate);
    wire        tick     = run_ff && (div_ff == half);
    wire        m_edge   = master && tick;
    wire        s_edge   = !master && sel_active && (sck_s != sck_prev_ff);
    wire        any_edge = m_edge || s_edge;
    wire        leading  = !edges_ff[0];
    wire        capture  = any_edge && (leading ^ cpha);
    wire        drive    = any_edge && !(leading ^ cpha);
    wire        last     = any_edge && (edges_ff == EDGES_PER_BYTE - 5'h01);

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst || !en)
        begin
            shreg_ff    <= DATA_RESET;
            out_ff      <= 1'b0;
            edges_ff    <= 5'h00;
            run_ff      <= 1'b0;
            sck_ff      <= 1'b0;
            sck_prev_ff <= 1'b0;
            div_ff      <= 7'h00;
            done_ff     <= 1'b0;
        end
        else
        begin
            sck_prev_ff <= sck_s;
            done_ff     <= last;
            div_ff      <= (tick || !run_ff) ? 7'h00 : div_ff + 7'h01;
            if (load)
            begin
                shreg_ff <= load_data;
                out_ff   <= load_data[7];
                edges_ff <= 5'h00;
                run_ff   <= master;
            end
            else
            begin
                if (any_edge)
                    edges_ff <= last ? 5'h00 : edges_ff + 5'h01;
                else if (!master && !sel_active)
                    edges_ff <= 5'h00;
                if (capture)
                    shreg_ff <= {shreg_ff[6:0], din_s};
                if (drive)
                    out_ff <= shreg_ff[7];
                if (m_edge)
                    sck_ff <= !sck_ff;
                if (last)
                    run_ff <= 1'b0;
            end
        end
    end

    // Idle level follows polarity since the toggle count is always even
    assign sck_drv = cpol ^ sck_ff;
    assign dout    = out_ff;
    assign rx_byte = shreg_ff;
    assign done    = done_ff;
    assign busy    = run_ff || (edges_ff != 5'h00);
endmodule : ssdr_shift

// ===== verilog/ssdr_top.sv
// Functional notes
// - Transfer done sets bit 7, may interrupt
// - Done clears: status access, then data access
// - Data writes ignored until status access
// - Write during transfer sets collision bit 6
// - New byte while done set: overrun
// - Status read clears overrun flag
// - Master with select low: mode fault
// - Fault clears: control access, then control write
// - Output disable stops serial data drive
// - Soft select source ignores select pin
// - Soft select level: zero selects slave
// - Master data write starts one byte
// - Received byte copied to read buffer
// - Data write loads shift register directly
// - Mode fault clears enable and master
// - Shared interrupt from done, fault, overrun
// - Write collision never interrupts
`timescale 1ns/1ps
module ssdr_top (
    input  wire logic       clk_sys,
    input  wire logic       sys_rst,
    input  wire logic [7:0] bus_addr,
    input  wire logic [7:0] bus_wdata,
    input  wire logic       bus_wr,
    input  wire logic       bus_rd,
    output logic      [7:0] bus_rdata,
    output logic            irq,
    input  wire logic       sck_in,
    output logic            sck_out,
    output logic            sck_oe,
    input  wire logic       mosi_in,
    output logic            mosi_out,
    output logic            mosi_oe,
    input  wire logic       miso_in,
    output logic            miso_out,
    output logic            miso_oe,
    input  wire logic       ss_n_in
);
    import ssdr_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0] ctrl_ff;
    logic [7:0] nxt_ctrl;
    logic       done_flag_ff;
    logic       nxt_done_flag;
    logic       coll_flag_ff;
    logic       nxt_coll_flag;
    logic       ovr_flag_ff;
    logic       nxt_ovr_flag;
    logic       fault_flag_ff;
    logic       nxt_fault_flag;
    logic [2:0] csr_cfg_ff;
    logic [2:0] nxt_csr_cfg;
    logic       done_armed_ff;
    logic       nxt_done_armed;
    logic       coll_armed_ff;
    logic       nxt_coll_armed;
    logic       fault_armed_ff;
    logic       nxt_fault_armed;
    logic [7:0] rx_buf_ff;
    logic [7:0] nxt_rx_buf;
    logic [2:0] evt_stat_ff;
    logic [2:0] nxt_evt_stat;
    logic [2:0] evt_en_ff;
    logic [2:0] nxt_evt_en;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic       irq_ff;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [3:0] pins_s;
    wire        sck_s   = pins_s[0];
    wire        mosi_s  = pins_s[1];
    wire        miso_s  = pins_s[2];
    wire        ss_n_s  = pins_s[3];

    ssdr_sync #(
        .W       (4)
    ) u_sync (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .d_async ({ss_n_in, miso_in, mosi_in, sck_in}),
        .d_sync  (pins_s)
    );

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire sel_data  = (bus_addr == ADDR_DATA_BUFFER);
    wire sel_ctrl  = (bus_addr == ADDR_CONTROL);
    wire sel_csr   = (bus_addr == ADDR_CONTROL_STAT);
    wire sel_estat = (bus_addr == ADDR_EVT_STATUS);
    wire sel_eclr  = (bus_addr == ADDR_EVT_CLEAR);
    wire sel_een   = (bus_addr == ADDR_EVT_ENABLE);

    wire data_wr   = bus_wr && sel_data;
    wire data_rd   = bus_rd && sel_data;
    wire data_acc  = data_wr || data_rd;
    wire ctrl_wr   = bus_wr && sel_ctrl;
    wire ctrl_acc  = (bus_wr || bus_rd) && sel_ctrl;
    wire csr_wr    = bus_wr && sel_csr;
    wire csr_rd    = bus_rd && sel_csr;
    wire csr_acc   = csr_wr || csr_rd;
    wire eclr_wr   = bus_wr && sel_eclr;
    wire een_wr    = bus_wr && sel_een;

    // ------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------
    wire       irq_enable    = ctrl_ff[CR_IRQ_ENABLE];
    wire       port_enable   = ctrl_ff[CR_PORT_ENABLE];
    wire       master_select = ctrl_ff[CR_MASTER_SELECT];
    wire       cpol          = ctrl_ff[CR_CPOL];
    wire       cpha          = ctrl_ff[CR_CPHA];
    wire [2:0] rate          = {ctrl_ff[CR_RATE_HI], ctrl_ff[CR_RATE_MID], ctrl_ff[CR_RATE_LO]};

    wire output_disable     = csr_cfg_ff[CSR_OUTPUT_DISABLE];
    wire select_source_soft = csr_cfg_ff[CSR_SELECT_SOFT];
    wire soft_select_level  = csr_cfg_ff[CSR_SOFT_LEVEL];

    // ------------------------------------------------------------
    // Internal slave select
    // ------------------------------------------------------------
    // Pin ignored in soft mode
    wire ss_int_n   = select_source_soft ? soft_select_level : ss_n_s;
    wire sel_active = port_enable && !master_select && !ss_int_n;

    // ------------------------------------------------------------
    // Shift engine
    // ------------------------------------------------------------
    logic       eng_busy;
    logic       eng_done;
    logic [7:0] eng_rx;
    logic       eng_sck;
    logic       eng_dout;

    wire wr_blocked = done_flag_ff && !done_armed_ff;
    // Write during a live byte collides
    wire wr_collide = data_wr && !wr_blocked && eng_busy;
    wire wr_load    = data_wr && !wr_blocked && !eng_busy;

    ssdr_shift u_shift (
        .clk_sys    (clk_sys),
        .sys_rst    (sys_rst),
        .en         (port_enable),
        .master     (master_select),
        .cpol       (cpol),
        .cpha       (cpha),
        .rate       (rate),
        .load       (wr_load),
        .load_data  (bus_wdata),
        .sck_s      (sck_s),
        .din_s      (master_select ? miso_s : mosi_s),
        .sel_active (sel_active),
        .busy       (eng_busy),
        .done       (eng_done),
        .rx_byte    (eng_rx),
        .sck_drv    (eng_sck),
        .dout       (eng_dout)
    );

    // ------------------------------------------------------------
    // Events
    // ------------------------------------------------------------
    // Byte lands while done still set
    wire ovr_event   = eng_done && done_flag_ff;
    wire fault_event = master_select && !ss_int_n;

    // ------------------------------------------------------------
    // Transfer done and buffer
    // ------------------------------------------------------------
    // Buffer keeps the older byte on overrun, so the newly received byte is lost
    always_comb
    begin
        nxt_done_flag  = done_flag_ff;
        nxt_done_armed = done_armed_ff;
        nxt_rx_buf     = rx_buf_ff;
        if (csr_acc && done_flag_ff)
            nxt_done_armed = 1'b1;
        // Clear on data access after arming
        if (data_acc && done_armed_ff)
        begin
            nxt_done_flag  = 1'b0;
            nxt_done_armed = 1'b0;
        end
        // A same-cycle clear wins; the new byte then counts as overrun
        if (eng_done && !ovr_event)
        begin
            nxt_done_flag  = 1'b1;
            nxt_done_armed = 1'b0;
        end
        if (eng_done && !ovr_event)
            nxt_rx_buf = eng_rx;
    end

    // ------------------------------------------------------------
    // Collision and overrun
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_coll_flag  = coll_flag_ff;
        nxt_coll_armed = coll_armed_ff;
        nxt_ovr_flag   = ovr_flag_ff;
        if (csr_rd && coll_flag_ff)
            nxt_coll_armed = 1'b1;
        if (data_rd && coll_armed_ff)
        begin
            nxt_coll_flag  = 1'b0;
            nxt_coll_armed = 1'b0;
        end
        if (wr_collide)
        begin
            nxt_coll_flag  = 1'b1;
            nxt_coll_armed = 1'b0;
        end
        if (csr_rd)
            nxt_ovr_flag = 1'b0;
        if (ovr_event)
            nxt_ovr_flag = 1'b1;
    end

    // ------------------------------------------------------------
    // Mode fault and control register
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_fault_flag  = fault_flag_ff;
        nxt_fault_armed = fault_armed_ff;
        nxt_ctrl        = ctrl_ff;
        // Arm on control access while set
        if (ctrl_acc && fault_flag_ff)
            nxt_fault_armed = 1'b1;
        if (ctrl_wr)
            nxt_ctrl = bus_wdata;
        if (ctrl_wr && fault_armed_ff)
        begin
            nxt_fault_flag  = 1'b0;
            nxt_fault_armed = 1'b0;
        end
        if (fault_event)
        begin
            nxt_fault_flag  = 1'b1;
            nxt_fault_armed = 1'b0;
        end
        if (fault_event)
        begin
            nxt_ctrl[CR_PORT_ENABLE]   = 1'b0;
            nxt_ctrl[CR_MASTER_SELECT] = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Configuration and event registers
    // ------------------------------------------------------------
    // Reserved bit stored nowhere, reads zero
    assign nxt_csr_cfg = csr_wr ? bus_wdata[2:0] : csr_cfg_ff;
    assign nxt_evt_en  = een_wr ? bus_wdata[2:0] : evt_en_ff;

    wire [2:0] evt_set = {fault_event, ovr_event, eng_done && !ovr_event};
    wire [2:0] evt_clr = eclr_wr ? bus_wdata[2:0] : 3'h0;
    assign nxt_evt_stat = (evt_stat_ff & ~evt_clr) | evt_set;

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    wire [7:0] csr_view = {done_flag_ff, coll_flag_ff, ovr_flag_ff, fault_flag_ff,
                           1'b0, csr_cfg_ff};

    always_comb
    begin
        nxt_rdata = 8'h00;
        if (bus_rd)
        begin
            case (1'b1)
                sel_data:  nxt_rdata = rx_buf_ff;
                sel_ctrl:  nxt_rdata = ctrl_ff;
                sel_csr:   nxt_rdata = csr_view;
                sel_estat: nxt_rdata = {5'h00, evt_stat_ff};
                sel_een:   nxt_rdata = {5'h00, evt_en_ff};
                default:   nxt_rdata = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Interrupt
    // ------------------------------------------------------------
    // Shared request from three flags
    // Collision kept out of the request
    wire flag_irq = irq_enable && (done_flag_ff || fault_flag_ff || ovr_flag_ff);
    wire evt_irq  = |(evt_stat_ff & evt_en_ff);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            ctrl_ff    <= CR_RESET;
            csr_cfg_ff <= CSR_RESET[2:0];
            rx_buf_ff  <= DATA_RESET;
            rdata_ff   <= 8'h00;
            irq_ff     <= 1'b0;
        end
        else
        begin
            ctrl_ff    <= nxt_ctrl;
            csr_cfg_ff <= nxt_csr_cfg;
            rx_buf_ff  <= nxt_rx_buf;
            rdata_ff   <= nxt_rdata;
            irq_ff     <= flag_irq || evt_irq;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            done_flag_ff   <= CSR_RESET[CSR_TRANSFER_DONE];
            coll_flag_ff   <= CSR_RESET[CSR_WRITE_COLL];
            ovr_flag_ff    <= CSR_RESET[CSR_OVERRUN];
            fault_flag_ff  <= CSR_RESET[CSR_MODE_FAULT];
            done_armed_ff  <= 1'b0;
            coll_armed_ff  <= 1'b0;
            fault_armed_ff <= 1'b0;
        end
        else
        begin
            done_flag_ff   <= nxt_done_flag;
            coll_flag_ff   <= nxt_coll_flag;
            ovr_flag_ff    <= nxt_ovr_flag;
            fault_flag_ff  <= nxt_fault_flag;
            done_armed_ff  <= nxt_done_armed;
            coll_armed_ff  <= nxt_coll_armed;
            fault_armed_ff <= nxt_fault_armed;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            evt_stat_ff <= EVT_RESET;
            evt_en_ff   <= EVT_RESET;
        end
        else
        begin
            evt_stat_ff <= nxt_evt_stat;
            evt_en_ff   <= nxt_evt_en;
        end
    end

    // ------------------------------------------------------------
    // Pins
    // ------------------------------------------------------------
    // Data output gated by disable bit
    wire data_drive = port_enable && !output_disable;

    assign sck_out   = eng_sck;
    assign sck_oe    = port_enable && master_select;
    assign mosi_out  = eng_dout;
    assign mosi_oe   = data_drive && master_select;
    assign miso_out  = eng_dout;
    assign miso_oe   = data_drive && sel_active;
    assign bus_rdata = rdata_ff;
    assign irq       = irq_ff;
endmodule : ssdr_top

// ===== verification/ssdr_assertions.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port-level checks of the serial block
// ----------------------------------------
module ssdr_chk
    import ssdr_pkg::*;
(
    input wire logic       clk_sys,
    input wire logic       sys_rst,
    input wire logic [7:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic       bus_wr,
    input wire logic       bus_rd,
    input wire logic [7:0] bus_rdata,
    input wire logic       irq,
    input wire logic       sck_in,
    input wire logic       sck_out,
    input wire logic       sck_oe,
    input wire logic       mosi_in,
    input wire logic       mosi_out,
    input wire logic       mosi_oe,
    input wire logic       miso_in,
    input wire logic       miso_out,
    input wire logic       miso_oe,
    input wire logic       ss_n_in
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    logic       ssm_ff;
    logic       ien_ff;
    logic [2:0] een_ff;
    // Shadow of the enables; hardware never sets them
    wire        masked = !ien_ff && een_ff == 3'h0;
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            {ssm_ff, ien_ff, een_ff} <= 5'h00;
        else if (bus_wr && bus_addr == ADDR_CONTROL_STAT)
            ssm_ff <= bus_wdata[CSR_SELECT_SOFT];
        else if (bus_wr && bus_addr == ADDR_CONTROL)
            ien_ff <= bus_wdata[CR_IRQ_ENABLE];
        else if (bus_wr && bus_addr == ADDR_EVT_ENABLE)
            een_ff <= bus_wdata[2:0];
    end
    a_rdata_quiet: assert property (!$past(bus_rd) |-> bus_rdata == 8'h00)
        else $error("read data not zero outside a read");
    a_resv_zero: assert property ($past(bus_rd && bus_addr == ADDR_CONTROL_STAT) |->
        !bus_rdata[3]) else $error("reserved status bit read as one");
    a_oe_single: assert property (!(mosi_oe && miso_oe))
        else $error("both data outputs driven");
    a_mosi_master: assert property (mosi_oe |-> sck_oe)
        else $error("data out driven without clock drive");
    a_fault_drop: assert property ($fell(ss_n_in) && sck_oe && !ssm_ff |->
        ##[1:6] !sck_oe) else $error("master kept after select fault");
    a_irq_masked: assert property ($past(masked) && masked |-> !irq)
        else $error("interrupt while all enables off");
    a_irq_cause: assert property ($rose(irq) |-> !$past(masked))
        else $error("interrupt rose with no enable");
    a_sck_half: assert property ($changed(sck_out) |=> $stable(sck_out))
        else $error("serial clock half period too short");
    c_irq: cover property ($rose(irq));
    c_fault: cover property ($fell(sck_oe));
    c_shift: cover property (mosi_oe && $changed(sck_out));
endmodule : ssdr_chk

bind ssdr_top ssdr_chk ssdr_chk_inst (.clk_sys, .sys_rst, .bus_addr, .bus_wdata, .bus_wr,
    .bus_rd, .bus_rdata, .irq, .sck_in, .sck_out, .sck_oe, .mosi_in, .mosi_out, .mosi_oe,
    .miso_in, .miso_out, .miso_oe, .ss_n_in);

// ===== verification/ssdr_slave_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Slave device, clock phase 0, polarity 0
// ----------------------------------------
module ssdr_slave_model (
    input  wire logic       sck,
    input  wire logic       sel_n,
    input  wire logic       mosi,
    input  wire logic [7:0] tx_byte,
    output logic            miso,
    output logic      [7:0] rx_byte
);
    logic [7:0] sh_ff;
    initial miso = 1'b0;
    initial rx_byte = 8'h00;
    always @(negedge sel_n)
    begin
        sh_ff = tx_byte;
        miso = tx_byte[7];
    end
    always @(posedge sck) if (!sel_n) rx_byte = {rx_byte[6:0], mosi};
    always @(negedge sck)
    begin
        if (!sel_n)
        begin
            sh_ff = {sh_ff[6:0], 1'b0};
            miso = sh_ff[7];
        end
    end
    // Released line flips so a stale bit never reads as valid
    always @(posedge sel_n) miso = ~miso;
endmodule : ssdr_slave_model

// ===== verification/ssdr_top_tb.sv
`timescale 1ns/1ps
module ssdr_top_tb;
    import ssdr_pkg::*;
    logic       clk_sys = 1'b0, sys_rst = 1'b1, bus_wr = 1'b0, bus_rd = 1'b0;
    logic       ss_n_in = 1'b1, sel_n = 1'b1, sck_m = 1'b0;
    logic [7:0] bus_addr = 8'h00, bus_wdata = 8'h00, bus_rdata, got, slv_rx;
    logic       irq, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, miso_w;
    int         err_count = 0, tests_run = 0;
    wire        sck_w = sck_oe ? sck_out : sck_m;
    wire        mosi_w = mosi_oe ? mosi_out : 1'b1;
    always #50 clk_sys = ~clk_sys;
    ssdr_top ssdr_top_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .irq(irq), .sck_in(sck_w), .sck_out(sck_out), .sck_oe(sck_oe), .mosi_in(mosi_w),
        .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_oe ? miso_out : miso_w),
        .miso_out(miso_out), .miso_oe(miso_oe), .ss_n_in(ss_n_in));
    ssdr_slave_model ssdr_slave_model_inst (.sck(sck_w), .sel_n(sel_n), .mosi(mosi_w),
        .tx_byte(8'h3C), .miso(miso_w), .rx_byte(slv_rx));
    task automatic close_out();
        $display("checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : close_out
    task automatic chk(input logic [7:0] act, input logic [7:0] exp);
        tests_run++;
        if (act !== exp)
        begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, act, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk_sys);
        bus_wr <= 1'b0;
    endtask : wr
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk_sys);
        bus_rd <= 1'b0;
        @(negedge clk_sys);
        chk(bus_rdata, exp);
    endtask : rdchk
    task automatic oechk(input logic [7:0] exp);
        @(negedge clk_sys);
        chk({5'h00, sck_oe, mosi_oe, miso_oe}, exp);
    endtask : oechk
    task automatic wait_irq(input logic lvl);
        int n;
        n = 0;
        while (irq !== lvl && n < 500)
        begin
            @(posedge clk_sys);
            n++;
        end
        chk({7'h00, irq}, {7'h00, lvl});
        if (irq !== lvl)
            close_out();
    endtask : wait_irq
    task automatic fault_chk(input logic [7:0] csr);
        wait_irq(1'b1);
        rdchk(ADDR_CONTROL_STAT, csr | 8'h10);
        rdchk(ADDR_CONTROL, 8'h80);
        oechk(8'h00);
        wr(ADDR_CONTROL, 8'h80);
        ss_n_in <= 1'b1;
        rdchk(ADDR_CONTROL_STAT, csr);
        wait_irq(1'b0);
    endtask : fault_chk
    initial
    begin
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rdchk(ADDR_CONTROL_STAT, CSR_RESET);
        rdchk(ADDR_CONTROL, CR_RESET);
        rdchk(8'h30, 8'h00);
        $display("test reset values ended");
        wr(ADDR_CONTROL_STAT, 8'h00);
        wr(ADDR_CONTROL, 8'hD0);
        sel_n <= 1'b0;
        wr(ADDR_DATA_BUFFER, 8'hA5);
        wr(ADDR_DATA_BUFFER, 8'h11);
        wait_irq(1'b1);
        wr(ADDR_DATA_BUFFER, 8'h55);
        rdchk(ADDR_CONTROL_STAT, 8'hC0);
        rdchk(ADDR_DATA_BUFFER, 8'h3C);
        chk(slv_rx, 8'hA5);
        rdchk(ADDR_CONTROL_STAT, 8'h00);
        wait_irq(1'b0);
        $display("test first byte ended");
        sel_n <= 1'b1;
        @(posedge clk_sys);
        sel_n <= 1'b0;
        wr(ADDR_DATA_BUFFER, 8'h5A);
        wait_irq(1'b1);
        rdchk(ADDR_CONTROL_STAT, 8'h80);
        wr(ADDR_DATA_BUFFER, 8'h96);
        wait_irq(1'b0);
        wait_irq(1'b1);
        chk(slv_rx, 8'h96);
        rdchk(ADDR_CONTROL_STAT, 8'h80);
        rdchk(ADDR_DATA_BUFFER, 8'h00);
        wait_irq(1'b0);
        $display("test write clear ended");
        wr(ADDR_CONTROL_STAT, 8'h04);
        oechk(8'h04);
        wr(ADDR_CONTROL_STAT, 8'h00);
        ss_n_in <= 1'b0;
        oechk(8'h06);
        fault_chk(8'h00);
        wr(ADDR_CONTROL, 8'hD0);
        wr(ADDR_CONTROL_STAT, 8'h03);
        ss_n_in <= 1'b0;
        repeat (8) @(posedge clk_sys);
        rdchk(ADDR_CONTROL_STAT, 8'h03);
        wr(ADDR_CONTROL_STAT, 8'h02);
        fault_chk(8'h02);
        $display("test mode fault ended");
        rdchk(ADDR_EVT_STATUS, 8'h05);
        rdchk(ADDR_EVT_ENABLE, 8'h00);
        wr(ADDR_EVT_ENABLE, 8'h04);
        wait_irq(1'b1);
        wr(ADDR_EVT_ENABLE, 8'h00);
        wait_irq(1'b0);
        wr(ADDR_EVT_CLEAR, 8'h05);
        rdchk(ADDR_EVT_STATUS, 8'h00);
        $display("test events ended");
        wr(ADDR_CONTROL, 8'hC0);
        repeat (32)
        begin
            sck_m <= ~sck_m;
            repeat (4) @(posedge clk_sys);
        end
        rdchk(ADDR_CONTROL_STAT, 8'hA2);
        rdchk(ADDR_CONTROL_STAT, 8'h82);
        rdchk(ADDR_DATA_BUFFER, 8'hFF);
        $display("test overrun ended");
        close_out();
    end
endmodule : ssdr_top_tb
